/* mgmt_frame_slave.sv */
/*
 * Serial management frame engine: decodes read and write frames and
 * drives read data. Assumes the management clock and data pins are
 * synchronous to clk_i and much slower than it.
 */
`timescale 1ns/100ps
`include "pcs_cfg_defs.svh"
module mgmt_frame_slave
    import pcs_cfg_pkg::*;
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Management pins.
    input wire logic mdc_i,
    input wire logic mdio_i,
    output logic mdio_o,
    output logic mdio_oe_n_o,
    // Port address.
    input wire logic [4:0] phy_addr_i,
    // Register access.
    input wire reg_word_t rd_data_i,
    output logic [4:0] reg_addr_o,
    output logic rd_o,
    output logic wr_o,
    output reg_word_t wr_data_o
);
    mgmt_state_e state_q;
    logic mdc_q;
    logic rise;
    logic is_read_q;
    logic [5:0] ones_q;
    logic [4:0] cnt_q;
    logic [12:0] hdr_q;
    logic [12:0] hdr_nx;
    reg_word_t sh_q;

    assign rise = mdc_i & ~mdc_q;
    assign hdr_nx = {hdr_q[11:0], mdio_i};

    always_ff @(posedge clk_i) begin
        mdc_q <= rst_i ? 1'b0 : mdc_i;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= MG_PRE;
            ones_q <= 6'h00;
            cnt_q <= 5'h00;
            hdr_q <= 13'h0000;
            is_read_q <= 1'b0;
            sh_q <= 16'h0000;
            reg_addr_o <= 5'h00;
            rd_o <= 1'b0;
            wr_o <= 1'b0;
            wr_data_o <= 16'h0000;
            mdio_o <= 1'b0;
            mdio_oe_n_o <= 1'b1;
        end else begin
            rd_o <= 1'b0;
            wr_o <= 1'b0;
            if (rise) begin
                case (state_q)
                    MG_PRE: begin
                        if (mdio_i) begin
                            if (ones_q != `MGMT_PREAMBLE) begin
                                ones_q <= ones_q + 6'h01;
                            end
                        end else begin
                            if (ones_q == `MGMT_PREAMBLE) begin
                                state_q <= MG_HDR;
                            end
                            ones_q <= 6'h00;
                            cnt_q <= 5'h00;
                        end
                    end
                    MG_HDR: begin
                        hdr_q <= hdr_nx;
                        cnt_q <= cnt_q + 5'h01;
                        if (cnt_q == `MGMT_HDR_LAST) begin
                            cnt_q <= 5'h00;
                            reg_addr_o <= hdr_nx[4:0];
                            is_read_q <= hdr_nx[11:10] == `MGMT_OP_READ;
                            state_q <= MG_PRE;
                            if (hdr_nx[12] && hdr_nx[9:5] == phy_addr_i) begin
                                if (hdr_nx[11:10] == `MGMT_OP_READ) begin
                                    state_q <= MG_TA;
                                end
                                if (hdr_nx[11:10] == `MGMT_OP_WRITE) begin
                                    state_q <= MG_DATA;
                                end
                            end
                        end
                    end
                    MG_TA: begin
                        rd_o <= 1'b1;
                        sh_q <= rd_data_i;
                        mdio_o <= 1'b0;
                        mdio_oe_n_o <= 1'b0;
                        state_q <= MG_DATA;
                    end
                    MG_DATA: begin
                        cnt_q <= cnt_q + 5'h01;
                        if (is_read_q) begin
                            mdio_o <= sh_q[15];
                            sh_q <= {sh_q[14:0], 1'b0};
                            if (cnt_q == `MGMT_RD_END) begin
                                mdio_oe_n_o <= 1'b1;
                                mdio_o <= 1'b0;
                                state_q <= MG_PRE;
                            end
                        end else begin
                            sh_q <= {sh_q[14:0], mdio_i};
                            if (cnt_q == `MGMT_WR_END) begin
                                wr_o <= 1'b1;
                                wr_data_o <= {sh_q[14:0], mdio_i};
                                state_q <= MG_PRE;
                            end
                        end
                    end
                    default: begin
                        state_q <= MG_PRE;
                    end
                endcase
            end
        end
    end
endmodule

/* mgmt_station.sv */
/*
 * Station manager model that clocks read and write frames on the
 * management pins. Assumes clk_i is the block clock and that the data
 * line has a pull-up, so it reads high whenever nobody drives it.
 */
`timescale 1ns/100ps
`include "pcs_cfg_defs.svh"
module mgmt_station (
    // Clock.
    input wire logic clk_i,
    // Management pins.
    output logic mdc_o,
    output logic mdio_line_o,
    input wire logic mdio_i,
    input wire logic mdio_oe_n_i
);
    logic drv;
    logic en;

    // The pull-up wins once both parties have let go of the line.
    assign mdio_line_o = !mdio_oe_n_i ? mdio_i : (en ? drv : 1'b1);

    initial begin
        mdc_o = 1'b0;
        drv = 1'b1;
        en = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    // One management clock period; the line is sampled late in the high
    // phase, after the block has had time to update its output.
    task automatic send_bit(input logic b, output logic s);
        drv = b;
        tick(4);
        mdc_o = 1'b1;
        tick(4);
        s = mdio_line_o;
        mdc_o = 1'b0;
    endtask

    task automatic xfer(input logic [4:0] phy, input logic [1:0] op,
                        input logic [4:0] ra, input logic [15:0] wd,
                        output logic [15:0] rd);
        logic s;
        logic [15:0] r;
        r = 16'h0000;
        en = 1'b1;
        for (int i = 0; i < 32; i++) send_bit(1'b1, s);
        send_bit(1'b0, s);
        send_bit(1'b1, s);
        send_bit(op[1], s);
        send_bit(op[0], s);
        for (int i = 4; i >= 0; i--) send_bit(phy[i], s);
        for (int i = 4; i >= 0; i--) send_bit(ra[i], s);
        if (op == `MGMT_OP_READ) begin
            en = 1'b0;
            for (int i = 0; i < 18; i++) begin
                send_bit(1'b1, s);
                if (i > 0 && i < 17) r = {r[14:0], s};
            end
        end else begin
            send_bit(1'b1, s);
            send_bit(1'b0, s);
            for (int i = 15; i >= 0; i--) send_bit(wd[i], s);
            en = 1'b0;
            send_bit(1'b1, s);
        end
        en = 1'b0;
        tick(8);
        rd = r;
    endtask
endmodule

/* pcs_cfg_defs.svh */
/*
 * Register offsets, field positions, reset values and timing figures of
 * the 100 Mb/s coding-sublayer register block. Definitions only.
 */
`ifndef PCS_CFG_DEFS_SVH
`define PCS_CFG_DEFS_SVH

`define CLK_FREQ_MHZ 200
`define DESC_TIMEOUT_SHORT_US 722
`define DESC_TIMEOUT_LONG_MS 2

`define REG_RX_ERR_CNT 5'h15
`define REG_PCS_CFG 5'h16

`define PCS_CFG_WR_MASK 16'h0FEF
`define PCS_CFG_RST_FIXED 16'h0100
`define PCS_CFG_STRAP_MASK 16'h004B

`define BIT_FREE_CLK 11
`define BIT_TRUE_QUIET 10
`define BIT_SD_FORCE 9
`define BIT_LINK_HOLD 8
`define BIT_DESC_LONG 7
`define BIT_FIBER 6
`define BIT_FORCE_GOOD 5
`define BIT_FEFI 3
`define BIT_NRZI_BYP 2
`define BIT_SCR_BYP 1
`define BIT_DESCR_BYP 0

`define ERR_CNT_RST 8'h00
`define ERR_CNT_MAX 8'hFF
`define ERR_CNT_HALF 8'h80

`define MGMT_PREAMBLE 6'h20
`define MGMT_HDR_LAST 5'h0C
`define MGMT_OP_READ 2'h2
`define MGMT_OP_WRITE 2'h1
`define MGMT_RD_END 5'h10
`define MGMT_WR_END 5'h11

`endif

/* pcs_cfg_pkg.sv */
/*
 * Types shared by the coding-sublayer register block.
 * Assumes nothing of its surroundings.
 */
package pcs_cfg_pkg;
    typedef enum logic {LINK_DOWN, LINK_UP} link_state_e;
    typedef enum logic [1:0] {MG_PRE, MG_HDR, MG_TA, MG_DATA} mgmt_state_e;
    typedef logic [15:0] reg_word_t;
endpackage

/* pcs_config_rx_error_counter.sv */
/*
 * Per-port receive symbol-error counter and 100 Mb/s coding-sublayer
 * configuration, reached over the serial management pins.
 * Assumes all inputs are synchronous to clk_i and that the fiber strap
 * is stable while rst_i is high.
 */
// Behaviour
// [RL1] Unused upper bits ignore writes, read zero
// [RL2] Count errored carrier events in low byte
// [RL3] At most one count per carrier event
// [RL4] No count if collision during the event
// [RL5] Counter saturates at maximum, never wraps
// [RL6] Counter resets zero, read-only, clears on read
// [RL7] Half-full posts flag cleared by status read
// [RL8] Bit 11 selects free-running receive clock
// [RL9] Bit 10 selects true-quiet transmit mode
// [RL10] Bit 9 forces signal detect active
// [RL11] Hold set: keep link despite lock loss
// [RL12] Hold clear: drop link on lock loss
// [RL13] Bit 7 picks 2ms or 722us timeout
// [RL14] Bit 6 fiber mode, reset from strap
// [RL15] Bit 5 forces 100 Mb/s link good
// [RL16] Bit 3 far-end fault, reset from strap
// [RL17] Bit 2 bypasses NRZI stage
// [RL18] Bit 1 scrambler bypass, reset from strap
// [RL19] Bit 0 descrambler bypass, reset from strap
// [RL20] Strap bits caught at reset, then writable
`timescale 1ns/100ps
`include "pcs_cfg_defs.svh"
module pcs_config_rx_error_counter
    import pcs_cfg_pkg::*;
#(
    parameter int DESC_SHORT_CYC = `DESC_TIMEOUT_SHORT_US * `CLK_FREQ_MHZ,
    parameter int DESC_LONG_CYC =
        `DESC_TIMEOUT_LONG_MS * 1000 * `CLK_FREQ_MHZ
)
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Straps.
    input wire logic fiber_strap_i,
    input wire logic [4:0] phy_addr_i,
    // Management pins.
    input wire logic mdc_i,
    input wire logic mdio_i,
    output logic mdio_o,
    output logic mdio_oe_n_o,
    // Receive path status.
    input wire logic carrier_valid_i,
    input wire logic invalid_symbol_i,
    input wire logic collision_i,
    input wire logic signal_level_ok_i,
    input wire logic descrambler_locked_i,
    input wire logic descrambler_idle_seen_i,
    // Interrupt status register read.
    input wire logic irq_status_read_i,
    // Configuration outputs.
    output logic rx_clk_free_run_o,
    output logic true_quiet_tx_enable_o,
    output logic signal_detect_force_o,
    output logic descrambler_long_timeout_o,
    output logic fiber_mode_enable_o,
    output logic far_end_fault_enable_o,
    output logic nrzi_bypass_o,
    output logic scrambler_bypass_o,
    output logic descrambler_bypass_o,
    // Status outputs.
    output logic link_100_up_o,
    output logic descrambler_sync_lost_o,
    output logic rx_err_half_full_event_o
);
    localparam int TMR_W = $clog2(DESC_LONG_CYC + 1);
    localparam logic [TMR_W-1:0] SHORT_LIM = TMR_W'(DESC_SHORT_CYC - 1);
    localparam logic [TMR_W-1:0] LONG_LIM = TMR_W'(DESC_LONG_CYC - 1);

    // *****************************************************************
    // Management access.
    // *****************************************************************
    function automatic logic reg_hit(input logic [4:0] a,
                                     input logic [4:0] off);
        return a == off;
    endfunction

    reg_word_t cfg_q;
    reg_word_t rd_data;
    reg_word_t wr_data;
    logic [4:0] reg_addr;
    logic rd_stb;
    logic wr_stb;
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;

    mgmt_frame_slave u_mgmt (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .mdc_i(mdc_i),
        .mdio_i(mdio_i),
        .mdio_o(mdio_o),
        .mdio_oe_n_o(mdio_oe_n_o),
        .phy_addr_i(phy_addr_i),
        .rd_data_i(rd_data),
        .reg_addr_o(reg_addr),
        .rd_o(rd_stb),
        .wr_o(wr_stb),
        .wr_data_o(wr_data)
    );

    // Upper bits are constant zero; unmapped addresses read zero.
    always_comb begin
        rd_data = 16'h0000;
        if (reg_hit(reg_addr, `REG_RX_ERR_CNT)) begin
            rd_data = {8'h00, cnt_q}; // [RL1]
        end else if (reg_hit(reg_addr, `REG_PCS_CFG)) begin
            rd_data = cfg_q;
        end
    end

    // *****************************************************************
    // Configuration register.
    // *****************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_q <= `PCS_CFG_RST_FIXED |
                (fiber_strap_i ? `PCS_CFG_STRAP_MASK : 16'h0000); // [RL20]
        end else if (wr_stb && reg_hit(reg_addr, `REG_PCS_CFG)) begin
            cfg_q <= wr_data & `PCS_CFG_WR_MASK; // [RL1]
        end
    end

    assign rx_clk_free_run_o = cfg_q[`BIT_FREE_CLK]; // [RL8]
    assign true_quiet_tx_enable_o = cfg_q[`BIT_TRUE_QUIET]; // [RL9]
    assign signal_detect_force_o = cfg_q[`BIT_SD_FORCE]; // [RL10]
    assign descrambler_long_timeout_o = cfg_q[`BIT_DESC_LONG]; // [RL13]
    assign fiber_mode_enable_o = cfg_q[`BIT_FIBER]; // [RL14]
    assign far_end_fault_enable_o = cfg_q[`BIT_FEFI]; // [RL16]
    assign nrzi_bypass_o = cfg_q[`BIT_NRZI_BYP]; // [RL17]
    assign scrambler_bypass_o = cfg_q[`BIT_SCR_BYP]; // [RL18]
    assign descrambler_bypass_o = cfg_q[`BIT_DESCR_BYP]; // [RL19]

    // *****************************************************************
    // Receive error counter.
    // *****************************************************************
    logic carrier_q;
    logic err_seen_q;
    logic coll_seen_q;
    logic event_end;
    logic incr;
    logic rd_clear;
    logic half_q;
    logic incr_q;

    always_ff @(posedge clk_i) begin
        if (rst_i || !carrier_valid_i) begin
            err_seen_q <= 1'b0;
            coll_seen_q <= 1'b0;
        end else begin
            err_seen_q <= err_seen_q | invalid_symbol_i; // [RL2]
            coll_seen_q <= coll_seen_q | collision_i; // [RL4]
        end
    end

    always_ff @(posedge clk_i) begin
        carrier_q <= rst_i ? 1'b0 : carrier_valid_i;
    end

    // Counting at the end of the carrier event gives one step per event.
    assign event_end = carrier_q & ~carrier_valid_i; // [RL3]
    assign incr = event_end & err_seen_q & ~coll_seen_q
                & (cnt_q != `ERR_CNT_MAX); // [RL4] [RL5]
    assign rd_clear = rd_stb & reg_hit(reg_addr, `REG_RX_ERR_CNT);

    // A count taken on the capture or the clear edge of a read missed the
    // captured value, so it survives the clear as a count of one.
    always_comb begin
        cnt_d = cnt_q;
        if (incr) begin
            cnt_d = rd_clear ? 8'h01 : cnt_q + 8'h01; // [RL2]
        end else if (rd_clear) begin
            cnt_d = incr_q ? 8'h01 : `ERR_CNT_RST; // [RL6]
        end
    end

    always_ff @(posedge clk_i) begin
        incr_q <= rst_i ? 1'b0 : incr;
    end

    always_ff @(posedge clk_i) begin
        cnt_q <= rst_i ? `ERR_CNT_RST : cnt_d; // [RL6]
    end

    // Setting wins over the clear by the status read.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            half_q <= 1'b0;
        end else if (incr && cnt_d == `ERR_CNT_HALF) begin
            half_q <= 1'b1; // [RL7]
        end else if (irq_status_read_i) begin
            half_q <= 1'b0; // [RL7]
        end
    end

    assign rx_err_half_full_event_o = half_q;

    // *****************************************************************
    // Descrambler synchronisation timeout.
    // *****************************************************************
    logic [TMR_W-1:0] tmr_q;
    logic [TMR_W-1:0] tmr_lim;
    logic expired_q;
    logic lost_q;

    assign tmr_lim = cfg_q[`BIT_DESC_LONG] ? LONG_LIM : SHORT_LIM; // [RL13]

    always_ff @(posedge clk_i) begin
        if (rst_i || !descrambler_locked_i || descrambler_idle_seen_i) begin
            tmr_q <= '0;
            expired_q <= 1'b0;
            lost_q <= 1'b0;
        end else if (!expired_q && tmr_q >= tmr_lim) begin
            expired_q <= 1'b1; // [RL13]
            lost_q <= 1'b1;
        end else begin
            lost_q <= 1'b0;
            if (!expired_q) begin
                tmr_q <= tmr_q + 1'b1;
            end
        end
    end

    assign descrambler_sync_lost_o = lost_q;

    // *****************************************************************
    // 100 Mb/s link qualification.
    // *****************************************************************
    link_state_e link_q;
    link_state_e link_d;
    logic sig_ok;
    logic locked;
    logic link_out_q;

    assign sig_ok = signal_level_ok_i | cfg_q[`BIT_SD_FORCE]; // [RL10]
    assign locked = cfg_q[`BIT_DESCR_BYP]
                  | (descrambler_locked_i & ~expired_q);

    always_comb begin
        link_d = link_q;
        case (link_q)
            LINK_DOWN: begin
                if (sig_ok && locked) begin
                    link_d = LINK_UP; // [RL11] [RL12]
                end
            end
            LINK_UP: begin
                if (!sig_ok) begin
                    link_d = LINK_DOWN; // [RL11]
                end else if (!locked && !cfg_q[`BIT_LINK_HOLD]) begin
                    link_d = LINK_DOWN; // [RL12]
                end
            end
            default: begin
                link_d = LINK_DOWN;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        link_q <= rst_i ? LINK_DOWN : link_d;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            link_out_q <= 1'b0;
        end else begin
            link_out_q <= cfg_q[`BIT_FORCE_GOOD]
                        | (link_d == LINK_UP); // [RL15]
        end
    end

    assign link_100_up_o = link_out_q;

    // *****************************************************************
    // Assertions.
    // *****************************************************************
    reserved_zero_a: assert property ( // [RL1]
        @(posedge clk_i) disable iff (rst_i)
        rd_data[15:12] == 4'h0 && cfg_q[4] == 1'b0
        && (!reg_hit(reg_addr, `REG_RX_ERR_CNT) || rd_data[15:8] == 8'h00))
        else $error("Reserved bits read non-zero.");

    count_step_a: assert property ( // [RL2]
        @(posedge clk_i) disable iff (rst_i)
        event_end && err_seen_q && !coll_seen_q && !rd_clear
        && cnt_q != 8'hFF |=> cnt_q == $past(cnt_q) + 8'h01)
        else $error("Errored carrier event not counted.");

    one_per_event_a: assert property ( // [RL3]
        @(posedge clk_i) disable iff (rst_i)
        carrier_q && carrier_valid_i |=> cnt_q <= $past(cnt_q))
        else $error("Counter moved inside a carrier event.");

    collision_block_a: assert property ( // [RL4]
        @(posedge clk_i) disable iff (rst_i)
        event_end && coll_seen_q |=> cnt_q <= $past(cnt_q))
        else $error("Counted an event with collision.");

    count_saturate_a: assert property ( // [RL5]
        @(posedge clk_i) disable iff (rst_i)
        cnt_q == 8'hFF && !rd_clear |=> cnt_q == 8'hFF)
        else $error("Counter wrapped at maximum.");

    clear_on_read_a: assert property ( // [RL6]
        @(posedge clk_i) disable iff (rst_i)
        rd_clear && !incr && !incr_q |=> cnt_q == 8'h00)
        else $error("Counter not cleared by read.");

    half_flag_a: assert property ( // [RL7]
        @(posedge clk_i) disable iff (rst_i)
        cnt_q == 8'h7F ##1 cnt_q == 8'h80 |-> rx_err_half_full_event_o)
        else $error("Half-full flag missing.");

    link_hold_a: assert property ( // [RL11]
        @(posedge clk_i) disable iff (rst_i)
        link_q == LINK_UP && sig_ok && cfg_q[8] |=> link_q == LINK_UP)
        else $error("Link dropped with hold option set.");

    link_drop_a: assert property ( // [RL12]
        @(posedge clk_i) disable iff (rst_i)
        link_q == LINK_UP && !locked && !cfg_q[8] |=> link_q == LINK_DOWN)
        else $error("Link kept after lock loss.");

    timeout_len_a: assert property ( // [RL13]
        @(posedge clk_i) disable iff (rst_i)
        $rose(lost_q) |-> $past(tmr_q) >= $past(tmr_lim))
        else $error("Descrambler timeout fired early.");

    force_good_a: assert property ( // [RL15]
        @(posedge clk_i) disable iff (rst_i)
        cfg_q[5] |=> link_100_up_o)
        else $error("Forced link good not shown.");

    strap_capture_a: assert property ( // [RL20]
        @(posedge clk_i)
        rst_i |=> cfg_q == (16'h0100 | ($past(fiber_strap_i)
                                        ? 16'h004B : 16'h0000)))
        else $error("Strap not captured at reset.");
endmodule

/* testbench.sv */
/*
 * Self-checking bench for the coding-sublayer register block, with a
 * behavioural model of the counter, flag and configuration.
 * Assumes the station model drives every management frame.
 */
`timescale 1ns/100ps
`include "pcs_cfg_defs.svh"
module testbench;
    import pcs_cfg_pkg::*;
    localparam int SHORT = 20;
    localparam int LONG = 50;
    localparam int LIMIT = 60000;
    localparam logic [4:0] PHY = 5'h03;
    logic clk_i, rst_i, strap, carrier, inval, coll, sig_ok, locked;
    logic idle, irq_rd, mdc, mdio_w, mdio_o, oe_n, link, lost, half;
    logic [8:0] cfg_o;
    logic [15:0] cfg;
    int errors, check_count, cyc, cnt, c;
    logic half_m;

    mgmt_station st (.clk_i(clk_i), .mdc_o(mdc), .mdio_line_o(mdio_w),
        .mdio_i(mdio_o), .mdio_oe_n_i(oe_n));

    pcs_config_rx_error_counter #(.DESC_SHORT_CYC(SHORT),
        .DESC_LONG_CYC(LONG)) dut (.clk_i(clk_i), .rst_i(rst_i),
        .fiber_strap_i(strap), .phy_addr_i(PHY), .mdc_i(mdc),
        .mdio_i(mdio_w), .mdio_o(mdio_o), .mdio_oe_n_o(oe_n),
        .carrier_valid_i(carrier), .invalid_symbol_i(inval),
        .collision_i(coll), .signal_level_ok_i(sig_ok),
        .descrambler_locked_i(locked), .descrambler_idle_seen_i(idle),
        .irq_status_read_i(irq_rd), .rx_clk_free_run_o(cfg_o[8]),
        .true_quiet_tx_enable_o(cfg_o[7]), .signal_detect_force_o(cfg_o[6]),
        .descrambler_long_timeout_o(cfg_o[5]),
        .fiber_mode_enable_o(cfg_o[4]), .far_end_fault_enable_o(cfg_o[3]),
        .nrzi_bypass_o(cfg_o[2]), .scrambler_bypass_o(cfg_o[1]),
        .descrambler_bypass_o(cfg_o[0]), .link_100_up_o(link),
        .descrambler_sync_lost_o(lost), .rx_err_half_full_event_o(half));

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                     exp);
        end
    endtask

    task automatic reset(input logic s);
        rst_i = 1'b1;
        strap = s;
        tick(3);
        rst_i = 1'b0;
        cfg = `PCS_CFG_RST_FIXED | (s ? `PCS_CFG_STRAP_MASK : 16'h0000);
    endtask

    task automatic rd_chk(input logic [4:0] phy, input logic [4:0] ra,
                          input logic [15:0] exp);
        logic [15:0] v;
        st.xfer(phy, `MGMT_OP_READ, ra, 16'h0000, v);
        check(v, exp);
    endtask

    task automatic wr(input logic [4:0] ra, input logic [15:0] v);
        logic [15:0] d;
        st.xfer(PHY, `MGMT_OP_WRITE, ra, v, d);
        if (ra == `REG_PCS_CFG) cfg = v & `PCS_CFG_WR_MASK;
    endtask

    task automatic cfg_chk();
        logic [15:0] e;
        e = {7'h00, cfg[11:9], cfg[7:6], cfg[3:0]};
        check({7'h00, cfg_o}, e);
    endtask

    task automatic ev(input int n, input logic cl);
        for (int i = 0; i < 6; i++) begin
            carrier = 1'b1;
            inval = (i < n);
            coll = cl && (i == 2);
            tick(1);
        end
        carrier = 1'b0;
        inval = 1'b0;
        coll = 1'b0;
        tick(3);
        if (n > 0 && !cl && cnt < 255) begin
            cnt++;
            if (cnt == 128) half_m = 1'b1;
        end
    endtask

    task automatic lk(input logic s, input logic l, input logic e);
        sig_ok = s;
        locked = l;
        tick(4);
        check({15'h0000, link}, {15'h0000, e});
    endtask

    always @(posedge clk_i) begin
        cyc++;
        if (cyc == LIMIT) begin
            errors++;
            final_report();
        end
    end

    // ****************************************
    // Main sequence.
    // ****************************************
    initial begin
        {rst_i, strap, carrier, inval, coll, sig_ok} = 6'h20;
        {locked, idle, irq_rd, half_m} = 4'h0;
        {errors, check_count, cyc, cnt} = '0;
        void'($urandom(71));
        reset(1'b1);
        rd_chk(PHY, `REG_PCS_CFG, 16'h014B);
        cfg_chk();
        reset(1'b0);
        rd_chk(PHY, `REG_PCS_CFG, 16'h0100);
        cfg_chk();
        rd_chk(PHY, `REG_RX_ERR_CNT, 16'h0000);
        rd_chk(PHY ^ 5'h01, `REG_PCS_CFG, 16'hFFFF);
        for (int i = 0; i < 4; i++) begin
            wr(`REG_PCS_CFG, 16'($urandom));
            rd_chk(PHY, `REG_PCS_CFG, cfg);
            cfg_chk();
        end
        wr(`REG_PCS_CFG, 16'hFFFF);
        rd_chk(PHY, `REG_PCS_CFG, 16'h0FEF);
        cfg_chk();
        check({15'h0000, half}, 16'h0000);
        ev(3, 1'b0);
        ev(4, 1'b1);
        for (int i = 0; i < 20; i++) begin
            ev($urandom_range(3, 0), $urandom_range(3, 0) == 0);
        end
        rd_chk(PHY, `REG_RX_ERR_CNT, 16'(cnt));
        cnt = 0;
        rd_chk(PHY, `REG_RX_ERR_CNT, 16'h0000);
        wr(`REG_RX_ERR_CNT, 16'hFFFF);
        rd_chk(PHY, `REG_RX_ERR_CNT, 16'h0000);
        repeat (130) ev(1, 1'b0);
        check({15'h0000, half}, {15'h0000, half_m});
        irq_rd = 1'b1;
        tick(1);
        irq_rd = 1'b0;
        tick(2);
        check({15'h0000, half}, 16'h0000);
        repeat (130) ev(2, 1'b0);
        rd_chk(PHY, `REG_RX_ERR_CNT, 16'(cnt));
        idle = 1'b1;
        wr(`REG_PCS_CFG, 16'h0100);
        lk(1'b0, 1'b0, 1'b0);
        lk(1'b1, 1'b1, 1'b1);
        lk(1'b1, 1'b0, 1'b1);
        lk(1'b0, 1'b0, 1'b0);
        wr(`REG_PCS_CFG, 16'h0000);
        lk(1'b1, 1'b1, 1'b1);
        lk(1'b1, 1'b0, 1'b0);
        lk(1'b0, 1'b1, 1'b0);
        wr(`REG_PCS_CFG, 16'h0200);
        lk(1'b0, 1'b1, 1'b1);
        wr(`REG_PCS_CFG, 16'h0020);
        lk(1'b0, 1'b0, 1'b1);
        wr(`REG_PCS_CFG, 16'h0001);
        lk(1'b1, 1'b0, 1'b1);
        idle = 1'b0;
        for (int b = 0; b < 2; b++) begin
            wr(`REG_PCS_CFG, b ? 16'h0180 : 16'h0100);
            cfg_chk();
            lk(1'b1, 1'b0, 1'b1);
            locked = 1'b1;
            c = 0;
            while (lost !== 1'b1 && c < 200) begin
                tick(1);
                c++;
            end
            c = c - (b ? LONG : SHORT);
            check({15'h0000, c >= -1 && c <= 2}, 16'h0001);
        end
        final_report();
    end
endmodule
